// >>> dab_pkg.sv
package dab_pkg;
	// Address geometry
	localparam int unsigned BANK_BITS      = 2;
	localparam int unsigned ROW_BITS       = 13;
	localparam int unsigned COL_BITS_X16   = 9;
	localparam int unsigned COL_BITS_X32   = 8;
	localparam int unsigned COL_BITS_MAX   = 9;
	localparam int unsigned DQ_WIDTH       = 16;
	localparam int unsigned PREFETCH       = 4;
	localparam int unsigned BURST_LEN      = 4;
	localparam int unsigned FIFO_DEPTH     = 32;
	// Refresh timing
	localparam int unsigned CLK_PERIOD_PS  = 10000;
	localparam int unsigned AVERAGE_REFRESH_INTERVAL_NS = 7800;
	localparam int unsigned REFRESH_CYCLES = (AVERAGE_REFRESH_INTERVAL_NS * 1000) / CLK_PERIOD_PS;
	localparam int unsigned INIT_CYCLES    = 16;
	// Command codes
	typedef enum logic [2:0] {
		DAB_CMD_NOP,
		DAB_CMD_ACT,
		DAB_CMD_RD,
		DAB_CMD_WR,
		DAB_CMD_PRE,
		DAB_CMD_REF
	} dab_cmd_e;
endpackage

// >>> dab_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dab_if import dab_pkg::*; ();
	dab_cmd_e                  cmd;
	logic [BANK_BITS-1:0]      bank_select_bits;
	logic [ROW_BITS-1:0]       cmd_addr_bus;
	logic [DQ_WIDTH-1:0]       dq_ctl;
	logic                      dq_ctl_oe;
	logic [DQ_WIDTH/8-1:0]     write_byte_mask;
	logic [DQ_WIDTH-1:0]       dq_dev;
	logic                      dq_dev_oe;
	logic [DQ_WIDTH-1:0]       dq;
	logic                      init_done;
	assign dq = dq_dev_oe ? dq_dev : dq_ctl;
	modport ctl (output cmd, bank_select_bits, cmd_addr_bus, dq_ctl, dq_ctl_oe, write_byte_mask, init_done,
		input dq, dq_dev_oe);
	modport dev (input cmd, bank_select_bits, cmd_addr_bus, dq_ctl, dq_ctl_oe, write_byte_mask, init_done, dq,
		output dq_dev, dq_dev_oe);
endinterface
`default_nettype wire

// >>> dab_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module dab_fifo #(
	parameter int unsigned WIDTH = 64,
	parameter int unsigned DEPTH = 32
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	// Fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wr_q;
	logic [AW:0]      rd_q;
	wire              push = in_valid_i & in_ready_o;
	wire              pop  = out_valid_o & out_ready_i;
	assign in_ready_o  = (wr_q - rd_q) != (AW+1)'(DEPTH);
	assign out_valid_o = wr_q != rd_q;
	assign out_data_o  = mem_q[rd_q[AW-1:0]];
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_q[AW-1:0]] <= in_data_i;
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) wr_q <= wr_q + 1'b1;
			if (pop) rd_q <= rd_q + 1'b1;
		end
	end
endmodule // dab_fifo
`default_nettype wire

// >>> dab_device.sv
//
// Operation
// RULE_01: Lowest column bit is always zero
// RULE_02: Unused address bits are ignored
// RULE_03: Controller refreshes every 7.8 us average
// RULE_04: Four-word prefetch per internal access
// RULE_05: Two bits per pin per clock; the code moves one bit per pin per clock, on the rising edge only
// RULE_06: Accesses are bursts in order
// RULE_07: Controller initializes before normal traffic
// RULE_08: Idle means all banks precharged
// RULE_09: Four banks, 13 rows, 9/8 columns
// RULE_10: Controller masks bytes during writes
`timescale 1ns/1ps
`default_nettype none
module dab_device import dab_pkg::*; #(
	parameter int unsigned COL_BITS = COL_BITS_X16,
	parameter int unsigned MEM_WORDS = 64
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	// Link
	dab_if.dev        link,
	// Status
	output logic      idle_o,
	output logic      overflow_o
);
	localparam int unsigned WW = DQ_WIDTH * PREFETCH;
	localparam int unsigned MA = $clog2(MEM_WORDS);
	typedef enum logic [1:0] {DAB_S_IDLE, DAB_S_ACTIVE, DAB_S_READ, DAB_S_WRITE} dab_state_e;

	logic [WW-1:0]          mem_q [MEM_WORDS];
	dab_state_e             state_q;
	logic [(1<<BANK_BITS)-1:0] open_q;
	logic [1:0]             beat_q;
	logic [COL_BITS-1:0]    col_q;
	logic [WW-1:0]          word_q;
	logic [DQ_WIDTH-1:0]    dq_q;
	logic                   oe_q;
	logic                   idle_q;
	logic                   ovf_q;

	// Column from the address bus: unused upper bits dropped, bit zero forced low
	function automatic logic [COL_BITS-1:0] col_of(input logic [ROW_BITS-1:0] a);
		return {a[COL_BITS-1:1], 1'b0}; // RULE_01 RULE_02 RULE_09
	endfunction

	// Masked bytes keep what the array holds, so a beat only replaces unmasked bytes
	function automatic logic [WW-1:0] merge_beat(
		input logic [WW-1:0]         base,
		input logic [1:0]            pos,
		input logic [DQ_WIDTH-1:0]   data,
		input logic [DQ_WIDTH/8-1:0] mask
	);
		logic [WW-1:0] w;
		w = base;
		for (int b = 0; b < DQ_WIDTH/8; b++) begin
			if (!mask[b]) w[pos*DQ_WIDTH + b*8 +: 8] = data[b*8 +: 8]; // RULE_10
		end
		return w;
	endfunction

	////////////////////////////////////////////////////////////////
	// Bank keeps the top index bits, so banks never alias one another
	wire [MA-1:0] word_idx  = {link.bank_select_bits, col_q[MA-BANK_BITS+1:2]};
	wire [1:0]    burst_pos = col_q[1:0] + beat_q; // RULE_06
	wire          is_rd     = link.cmd == DAB_CMD_RD;
	wire          is_wr     = link.cmd == DAB_CMD_WR;
	wire          in_bank   = (state_q == DAB_S_IDLE) || (state_q == DAB_S_ACTIVE);
	wire          in_burst  = (state_q == DAB_S_READ) || (state_q == DAB_S_WRITE);
	wire          in_write  = state_q == DAB_S_WRITE;
	wire          last_beat = in_burst && (beat_q == 2'd3);
	wire          take_act  = link.init_done && (link.cmd == DAB_CMD_ACT);
	wire          take_pre  = link.cmd == DAB_CMD_PRE;
	wire          take_acc  = (state_q == DAB_S_ACTIVE) && (is_rd || is_wr);
	wire [WW-1:0] word_base = (beat_q == 2'd0) ? mem_q[word_idx] : word_q;
	wire [WW-1:0] word_next = merge_beat(word_base, burst_pos, link.dq, link.write_byte_mask);

	////////////////////////////////////////////////////////////////
	// Write data buffered through the FIFO, word and index travel together
	logic             fin_valid;
	logic             fin_ready;
	logic             fout_valid;
	logic [WW+MA-1:0] fout_data;
	logic [MA-1:0]    fidx_q;
	logic             push_q;
	dab_state_e       state_d;

	dab_fifo #(.WIDTH(WW+MA), .DEPTH(FIFO_DEPTH)) dab_fifo_i (
		.clk_i       (clk_i),
		.rst_b_i     (rst_b_i),
		.in_valid_i  (fin_valid),
		.in_ready_o  (fin_ready),
		.in_data_i   ({fidx_q, word_q}),
		.out_valid_o (fout_valid),
		.out_ready_i (1'b1),
		.out_data_o  (fout_data)
	);
	// Pushed one cycle after the last beat, once the word holds all four beats
	assign fin_valid = push_q;

	always_ff @(posedge clk_i) begin
		if (fout_valid) mem_q[fout_data[WW +: MA]] <= fout_data[WW-1:0]; // RULE_04
	end

	////////////////////////////////////////////////////////////////
	always_comb begin
		state_d = state_q;
		case (state_q)
			DAB_S_IDLE, DAB_S_ACTIVE: begin
				if (take_act) begin
					state_d = DAB_S_ACTIVE;
				end else if (take_pre) begin
					state_d = DAB_S_IDLE; // RULE_08
				end else if (take_acc) begin
					state_d = is_rd ? DAB_S_READ : DAB_S_WRITE;
				end
			end
			DAB_S_READ, DAB_S_WRITE: begin
				if (beat_q == 2'd3) begin
					state_d = DAB_S_ACTIVE;
				end
			end
			default: state_d = DAB_S_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			state_q <= DAB_S_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Open-bank map; ACT is ignored until the far end reports init done
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			open_q <= '0;
		end else if (in_bank && take_act) begin
			open_q[link.bank_select_bits] <= 1'b1;
		end else if (in_bank && take_pre) begin
			open_q <= '0; // RULE_08
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			beat_q <= '0;
			col_q  <= '0;
		end else if (take_acc) begin
			beat_q <= '0;
			col_q  <= col_of(link.cmd_addr_bus);
		end else if (in_burst) begin
			beat_q <= beat_q + 2'd1;
		end
	end

	////////////////////////////////////////////////////////////////
	// Four quarter-word beats per prefetch word
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			dq_q <= '0;
			oe_q <= 1'b0;
		end else begin
			oe_q <= state_q == DAB_S_READ;
			if (state_q == DAB_S_READ) begin
				dq_q <= mem_q[word_idx][burst_pos*DQ_WIDTH +: DQ_WIDTH]; // RULE_05
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			word_q <= '0;
			push_q <= 1'b0;
			fidx_q <= '0;
		end else begin
			push_q <= in_write && last_beat;
			if (in_write) begin
				word_q <= word_next;
			end
			if (in_write && last_beat) begin
				fidx_q <= word_idx;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Overflow is sticky; only reset clears it
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			idle_q <= 1'b1;
			ovf_q  <= 1'b0;
		end else begin
			idle_q <= (state_q == DAB_S_IDLE) && (open_q == '0); // RULE_08
			ovf_q  <= ovf_q | (push_q & ~fin_ready);
		end
	end

	////////////////////////////////////////////////////////////////
	assign link.dq_dev    = dq_q;
	assign link.dq_dev_oe = oe_q;
	assign idle_o         = idle_q;
	assign overflow_o     = ovf_q;
endmodule // dab_device
`default_nettype wire

// >>> dab_controller.sv
`timescale 1ns/1ps
`default_nettype none
module dab_controller import dab_pkg::*; #(
	parameter int unsigned REFRESH_PERIOD = REFRESH_CYCLES
) (
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_b_i,
	// User request
	input  wire logic                req_i,
	input  wire logic                req_wr_i,
	input  wire logic [BANK_BITS-1:0] req_bank_i,
	input  wire logic [COL_BITS_MAX-1:0] req_col_i,
	input  wire logic [DQ_WIDTH-1:0] wdata_i,
	input  wire logic [DQ_WIDTH/8-1:0] wmask_i,
	output logic                     busy_o,
	output logic [DQ_WIDTH-1:0]      rdata_o,
	output logic                     rvalid_o,
	// Link
	dab_if.ctl                       link
);
	typedef enum logic [2:0] {DAB_C_INIT, DAB_C_IDLE, DAB_C_ACT, DAB_C_XFER, DAB_C_PRE, DAB_C_REF} dab_cstate_e;
	dab_cstate_e             st_q;
	dab_cmd_e                cmd_q;
	logic [15:0]             cnt_q;
	logic [15:0]             ref_q;
	logic [3:0]              beat_q;
	logic                    wr_q;
	logic [BANK_BITS-1:0]    bank_q;
	logic [ROW_BITS-1:0]     addr_q;
	logic                    done_q;
	logic [DQ_WIDTH-1:0]     rd_q;
	logic                    rv_q;
	wire                     ref_due = ref_q >= 16'(REFRESH_PERIOD - 8);

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			st_q <= DAB_C_INIT; cmd_q <= DAB_CMD_NOP; cnt_q <= '0; ref_q <= '0;
			beat_q <= '0; wr_q <= 1'b0; bank_q <= '0; addr_q <= '0; done_q <= 1'b0;
			rd_q <= '0; rv_q <= 1'b0;
		end else begin
			cmd_q <= DAB_CMD_NOP;
			rv_q  <= 1'b0;
			ref_q <= ref_q + 16'd1;
			if (link.dq_dev_oe) begin
				rd_q <= link.dq;
				rv_q <= 1'b1;
			end
			case (st_q)
				DAB_C_INIT: begin
					cnt_q <= cnt_q + 16'd1;
					if (cnt_q == 16'(INIT_CYCLES)) begin
						done_q <= 1'b1; // RULE_07
						st_q <= DAB_C_IDLE;
					end
				end
				DAB_C_IDLE: if (ref_due) begin
					cmd_q <= DAB_CMD_REF; ref_q <= '0; st_q <= DAB_C_IDLE; // RULE_03
				end else if (req_i) begin
					cmd_q <= DAB_CMD_ACT; wr_q <= req_wr_i; bank_q <= req_bank_i;
					addr_q <= ROW_BITS'({req_col_i[COL_BITS_MAX-1:1], 1'b0}); // RULE_01 RULE_09
					st_q <= DAB_C_ACT;
				end
				DAB_C_ACT: begin
					cmd_q <= wr_q ? DAB_CMD_WR : DAB_CMD_RD; beat_q <= '0; st_q <= DAB_C_XFER;
				end
				DAB_C_XFER: begin
					beat_q <= beat_q + 4'd1;
					if (beat_q == 4'(BURST_LEN + 1)) st_q <= DAB_C_PRE; // RULE_05
				end
				DAB_C_PRE: begin
					cmd_q <= DAB_CMD_PRE; st_q <= DAB_C_IDLE;
				end
				default: st_q <= DAB_C_INIT;
			endcase
		end
	end

	assign link.cmd              = cmd_q;
	assign link.bank_select_bits = bank_q;
	assign link.cmd_addr_bus     = addr_q;
	assign link.init_done        = done_q;
	assign link.dq_ctl           = wdata_i;
	// Drive only in the four cycles the far end samples write beats
	assign link.dq_ctl_oe        = (st_q == DAB_C_XFER) && wr_q && (beat_q != 4'd0) && (beat_q <= 4'(BURST_LEN));
	assign link.write_byte_mask  = wmask_i; // RULE_10
	assign busy_o                = st_q != DAB_C_IDLE;
	assign rdata_o               = rd_q;
	assign rvalid_o              = rv_q;
endmodule // dab_controller
`default_nettype wire

// >>> dab_props.sv
`timescale 1ns/1ps
`default_nettype none
module dab_props import dab_pkg::*; #(
	parameter int unsigned REFRESH_PERIOD = REFRESH_CYCLES
) (
	// Clock and reset
	input wire logic                 clk_i,
	input wire logic                 rst_b_i,
	// Link
	input wire dab_cmd_e             cmd,
	input wire logic [BANK_BITS-1:0] bank_select_bits,
	input wire logic [ROW_BITS-1:0]  cmd_addr_bus,
	input wire logic                 dq_ctl_oe,
	input wire logic                 dq_dev_oe,
	input wire logic                 init_done
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	int unsigned gap_q;
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || cmd == DAB_CMD_REF)
			gap_q <= 0;
		else
			gap_q <= gap_q + 1;
	end
	a_act_then_access: assert property (cmd == DAB_CMD_ACT |=> cmd inside {DAB_CMD_RD, DAB_CMD_WR})
		else $error("no access after activate");
	a_write_four_beats: assert property (cmd == DAB_CMD_WR |=> dq_ctl_oe [*4] ##1 !dq_ctl_oe)
		else $error("write burst is not four beats");
	a_pre_after_burst: assert property (cmd inside {DAB_CMD_RD, DAB_CMD_WR} |-> ##7 cmd == DAB_CMD_PRE)
		else $error("bank not closed after burst");
	a_col_lsb_zero: assert property (cmd inside {DAB_CMD_RD, DAB_CMD_WR} |-> !cmd_addr_bus[0])
		else $error("lowest column bit sent");
	a_no_early_traffic: assert property (!init_done |-> !(cmd inside {DAB_CMD_ACT, DAB_CMD_RD, DAB_CMD_WR}))
		else $error("traffic before init");
	a_init_holds: assert property (init_done |=> init_done)
		else $error("init flag dropped");
	a_bank_held: assert property (cmd == DAB_CMD_ACT |=> $stable(bank_select_bits))
		else $error("bank changed inside access");
	a_one_driver: assert property (!(dq_ctl_oe && dq_dev_oe))
		else $error("both ends drive data");
	// Allows for init and one burst in flight before the first refresh
	a_refresh_gap: assert property (gap_q <= REFRESH_PERIOD + INIT_CYCLES + 10)
		else $error("refresh gap too long");
endmodule // dab_props
`default_nettype wire

// >>> ddr_sdram_address_and_burst_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ddr_sdram_address_and_burst_core_tb import dab_pkg::*;;
	localparam int unsigned RP = 40;
	logic                   clk_i = 1'b0;
	logic                   rst_b_i = 1'b0;
	logic                   req_i = 1'b0;
	logic                   req_wr_i = 1'b0;
	logic [1:0]             req_bank_i = '0;
	logic [8:0]             req_col_i = '0;
	logic [15:0]            wdata_i = '0;
	logic [1:0]             wmask_i = '0;
	logic                   busy_o, rvalid_o, idle_o, overflow_o;
	logic [15:0]            rdata_o;
	logic [15:0]            mem [4][16];
	int                     error_cnt = 0;
	int                     compares = 0;
	int                     ref_cnt = 0;
	always #5 clk_i = ~clk_i;
	dab_if dab_if_i ();
	dab_controller #(.REFRESH_PERIOD(RP)) dab_controller_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req_i),
		.req_wr_i(req_wr_i), .req_bank_i(req_bank_i), .req_col_i(req_col_i), .wdata_i(wdata_i), .wmask_i(wmask_i),
		.busy_o(busy_o), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .link(dab_if_i.ctl));
	dab_device dab_device_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(dab_if_i.dev), .idle_o(idle_o),
		.overflow_o(overflow_o));
	dab_props #(.REFRESH_PERIOD(RP)) dab_props_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .cmd(dab_if_i.cmd),
		.bank_select_bits(dab_if_i.bank_select_bits), .cmd_addr_bus(dab_if_i.cmd_addr_bus),
		.dq_ctl_oe(dab_if_i.dq_ctl_oe), .dq_dev_oe(dab_if_i.dq_dev_oe), .init_done(dab_if_i.init_done));
	always @(posedge clk_i) if (dab_if_i.cmd === DAB_CMD_REF) ref_cnt++;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic burst(input logic wr, input logic [1:0] b, input logic [8:0] c, input logic [15:0] d,
		input logic [1:0] m);
		int n;
		int k;
		logic [3:0] a;
		n = 0;
		k = 0;
		while (busy_o !== 1'b0 && n < 100) begin
			@(posedge clk_i); #1; n++;
		end
		{req_i, req_wr_i, req_bank_i, req_col_i, wmask_i} = {1'b1, wr, b, c, m};
		// A refresh may take the slot, so the request stands until taken
		n = 0;
		while (busy_o !== 1'b1 && n < 20) begin
			@(posedge clk_i); #1; n++;
		end
		req_i = 1'b0;
		n = 0;
		// Column bit 0 is dropped, so the wrap starts at the even column
		if (wr) begin
			while (dab_if_i.cmd !== DAB_CMD_WR && n < 20) begin
				@(posedge clk_i); #1; n++;
			end
			for (k = 0; k < 4; k++) begin
				@(posedge clk_i); #1;
				a = {c[3:2], 2'({c[1], 1'b0} + k)};
				wdata_i = d + 16'(k);
				if (!m[0]) mem[b][a][7:0] = wdata_i[7:0];
				if (!m[1]) mem[b][a][15:8] = wdata_i[15:8];
			end
		end else begin
			while (k < 4 && n < 20) begin
				@(posedge clk_i); #1; n++;
				if (rvalid_o === 1'b1) begin
					a = {c[3:2], 2'({c[1], 1'b0} + k)};
					chk(rdata_o, mem[b][a]);
					k++;
				end
			end
		end
		chk(16'(k), 16'h0004);
	endtask
	task automatic stop_test();
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic t_init();
		chk({14'h0, busy_o, idle_o}, 16'h0003);
		repeat (30) @(posedge clk_i);
		#1 chk({14'h0, dab_if_i.init_done, busy_o}, 16'h0002);
		$display("test init done");
	endtask
	task automatic t_wrap();
		burst(1'b1, 2'h1, 9'h004, 16'ha110, 2'h0);
		burst(1'b0, 2'h1, 9'h006, 16'h0000, 2'h0);
		$display("test wrap done");
	endtask
	task automatic t_col_lsb();
		burst(1'b1, 2'h2, 9'h00b, 16'hc3c0, 2'h0);
		burst(1'b0, 2'h2, 9'h00a, 16'h0000, 2'h0);
		$display("test column lsb done");
	endtask
	task automatic t_mask();
		burst(1'b1, 2'h1, 9'h004, 16'h5e70, 2'h1);
		burst(1'b0, 2'h1, 9'h004, 16'h0000, 2'h0);
		// Precharge follows the last beat, idle shows two cycles later
		repeat (4) @(posedge clk_i);
		#1 chk({15'h0, idle_o}, 16'h0001);
		$display("test mask done");
	endtask
	task automatic t_refresh();
		int r0;
		r0 = ref_cnt;
		repeat (2 * RP) @(posedge clk_i);
		#1 chk(16'((ref_cnt - r0) >= 2), 16'h0001);
		chk({15'h0, overflow_o}, 16'h0000);
		$display("test refresh done");
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		#1 rst_b_i = 1'b1;
		t_init();
		t_wrap();
		t_col_lsb();
		t_mask();
		t_refresh();
		stop_test();
	end
	initial begin
		#20000;
		error_cnt++;
		stop_test();
	end
endmodule // ddr_sdram_address_and_burst_core_tb
`default_nettype wire
